// ==== inc/cpr_pkg.sv ====
`default_nettype none
package cpr_pkg;
  // ----------------------------------------------------------------
  // condition flags register layout
  // ----------------------------------------------------------------
  localparam int CC_C = 0;
  localparam int CC_Z = 1;
  localparam int CC_N = 2;
  localparam int CC_I0 = 3;
  localparam int CC_H = 4;
  localparam int CC_I1 = 5;
  localparam int CC_FIX_LO = 6;
  localparam int CC_FIX_HI = 7;
  // undefined reset bits are taken as zero
  localparam logic [7:0] CC_RESET = 8'he8;
  localparam logic [7:0] CC_FIXED_ONES = 8'hc0;
  // ----------------------------------------------------------------
  // software priority codes {priority_bit_high, priority_bit_low}
  // ----------------------------------------------------------------
  localparam logic [1:0] PRI_LEVEL0 = 2'h2;
  localparam logic [1:0] PRI_LEVEL1 = 2'h1;
  localparam logic [1:0] PRI_LEVEL2 = 2'h0;
  localparam logic [1:0] PRI_LEVEL3 = 2'h3;
  // ----------------------------------------------------------------
  // stack
  // ----------------------------------------------------------------
  localparam logic [15:0] SP_RESET = 16'h01ff;
  localparam logic [7:0] SP_PAGE = 8'h01;
  localparam logic [7:0] SP_LOW_RESET = 8'hff;
  localparam int CALL_DEPTH = 2;
  localparam int CTX_DEPTH = 5;
  // ----------------------------------------------------------------
  // operation kinds and branch conditions
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    FK_NONE = 6'h01,
    FK_ADD = 6'h02,
    FK_SUB = 6'h04,
    FK_LOGIC = 6'h08,
    FK_SHIFT = 6'h10,
    FK_BTJ = 6'h20
  } cpr_fkind_t;
  typedef enum logic [7:0] {
    BR_HALF_SET = 8'h01,
    BR_HALF_CLR = 8'h02,
    BR_NEG = 8'h04,
    BR_POS = 8'h08,
    BR_ZERO = 8'h10,
    BR_NONZERO = 8'h20,
    BR_CARRY_SET = 8'h40,
    BR_CARRY_CLR = 8'h80
  } cpr_branch_t;
endpackage
`default_nettype wire

// ==== inc/cpr_flag_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface cpr_flag_if;
  cpr_pkg::cpr_fkind_t kind;
  logic [7:0] opa;
  logic [7:0] opb;
  logic cin;
  logic [7:0] res;
  logic half;
  logic neg;
  logic zero;
  logic carry;
  logic upd_h;
  logic upd_nz;
  logic upd_c;
  modport core (output kind, opa, opb, cin,
                input res, half, neg, zero, carry, upd_h, upd_nz, upd_c);
  modport calc (input kind, opa, opb, cin,
                output res, half, neg, zero, carry, upd_h, upd_nz, upd_c);
endinterface
`default_nettype wire

// ==== core/cpr_flag_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpr_flag_calc (
  cpr_flag_if.calc fl
);
  // ----------------------------------------------------------------
  // result and flag arithmetic
  // ----------------------------------------------------------------
  wire logic [8:0] sum9;
  wire logic [8:0] dif9;
  wire logic [4:0] nib5;
  wire logic is_add;
  wire logic is_sub;
  wire logic is_pass;
  assign is_add = (fl.kind == cpr_pkg::FK_ADD);
  assign is_sub = (fl.kind == cpr_pkg::FK_SUB);
  assign is_pass = (fl.kind == cpr_pkg::FK_LOGIC)
                 || (fl.kind == cpr_pkg::FK_SHIFT);
  assign sum9 = {1'b0, fl.opa} + {1'b0, fl.opb} + {8'h00, fl.cin};
  assign dif9 = {1'b0, fl.opa} - {1'b0, fl.opb} - {8'h00, fl.cin};
  // RL9 carry out of bit 3
  assign nib5 = {1'b0, fl.opa[3:0]} + {1'b0, fl.opb[3:0]}
              + {4'h0, fl.cin};
  assign fl.res = is_add ? sum9[7:0] : (is_sub ? dif9[7:0] : fl.opb);
  assign fl.half = nib5[4];
  // RL10 sign copy
  assign fl.neg = fl.res[7];
  // RL11 zero detect
  assign fl.zero = (fl.res == 8'h00);
  // RL12 overflow or borrow; shifts and bit tests pass carry in cin
  assign fl.carry = is_add ? sum9[8] : (is_sub ? dif9[8] : fl.cin);
  assign fl.upd_h = is_add;
  assign fl.upd_nz = is_add || is_sub || is_pass;
  assign fl.upd_c = is_add || is_sub || (fl.kind == cpr_pkg::FK_SHIFT)
                  || (fl.kind == cpr_pkg::FK_BTJ);
endmodule // cpr_flag_calc
`default_nettype wire

// ==== core/cpr_stack_ptr.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpr_stack_ptr (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic push,
  input wire logic pop,
  input wire logic reset_op,
  input wire logic load,
  input wire logic [7:0] load_val,
  output logic [15:0] sp,
  output logic [15:0] addr
);
  logic [7:0] sp_low;
  wire logic [7:0] next_sp_low;
  // ----------------------------------------------------------------
  // low byte only; the page is fixed, so over/underflow wraps silently
  // ----------------------------------------------------------------
  // RL18 fixed page, post-dec, pre-inc
  assign next_sp_low = reset_op ? cpr_pkg::SP_LOW_RESET
                     : load ? load_val
                     : push ? sp_low - 8'h01
                     : pop ? sp_low + 8'h01
                     : sp_low;
  assign sp = {cpr_pkg::SP_PAGE, sp_low};
  assign addr = {cpr_pkg::SP_PAGE, pop ? sp_low + 8'h01 : sp_low};
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      sp_low <= cpr_pkg::SP_LOW_RESET;
    else if (clk_en)
      sp_low <= next_sp_low;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sp_push_a: assert property (clk_en && push && !pop // RL18
    && !load && !reset_op
    |=> sp_low == $past(sp_low) - 8'h01)
    else $error("push did not decrement stack pointer");
  sp_pop_a: assert property (clk_en && pop && !push // RL18
    && !load && !reset_op
    |-> addr[7:0] == sp_low + 8'h01 ##1 sp_low == $past(addr[7:0]))
    else $error("pop did not pre-increment stack pointer");
  sp_rsp_a: assert property (clk_en && reset_op // RL18
    |=> sp == cpr_pkg::SP_RESET)
    else $error("stack reset op did not reload top");
  sp_page_a: assert property (sp[15:8] == cpr_pkg::SP_PAGE) // RL18
    else $error("stack page moved");
endmodule // cpr_stack_ptr
`default_nettype wire

// ==== core/cpr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RL1 - 8-bit accumulator holds operands and results.
// RL2 - two 8-bit index registers for addressing or temporary data.
// RL3 - prefix steers next instruction's index operand to second index.
// RL4 - second index register untouched by interrupt entry and return.
// RL5 - 16-bit program counter built from separate low and high bytes.
// RL6 - core registers reached only through dedicated ports, not memory.
// RL7 - 8-bit flags register, priority field plus four flags, resets 111x1xxx.
// RL8 - whole flags register pushable and poppable; each flag testable.
// RL9 - half carry set on carry from bit 3 during add.
// RL10 - negative flag copies result bit 7.
// RL11 - zero flag set when result is zero.
// RL12 - carry flag set on overflow or borrow of arithmetic.
// RL13 - set and reset carry ops force carry; shifts, bit tests update it.
// RL14 - relative branches test each flag set or clear.
// RL15 - priority bits 5,3 encode levels 0 to 3; 11 disables interrupts.
// RL16 - interrupt entry loads priority bits from priority registers.
// RL17 - enable, disable, return, halt, wait, pop also change priority bits.
// RL18 - 16-bit stack pointer resets 01FF; post-decrement, pre-increment.
// RL19 - call uses two stack bytes, interrupt context five, low PC first.
// RL20 - flags bits 7 and 6 read one, writes ignored.
module cpr_regs (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic instr_done,
  input wire logic prefix_op,
  input wire logic acc_we,
  input wire logic [7:0] acc_wdata,
  input wire logic idx_we,
  input wire logic [7:0] idx_wdata,
  input wire logic pc_low_we,
  input wire logic pc_high_we,
  input wire logic [7:0] pc_byte,
  input wire logic pc_inc,
  input wire logic flag_upd,
  input wire cpr_pkg::cpr_fkind_t flag_kind,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic alu_cin,
  input wire logic set_carry_op,
  input wire logic reset_carry_op,
  input wire logic cc_pop,
  input wire logic [7:0] cc_wdata,
  input wire logic irq_entry,
  input wire logic [1:0] irq_pri_bits,
  input wire logic interrupt_enable_op,
  input wire logic interrupt_disable_op,
  input wire logic halt_op,
  input wire logic wait_interrupt_op,
  input wire cpr_pkg::cpr_branch_t branch_cond,
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic sp_reset_op,
  input wire logic sp_load,
  input wire logic [7:0] sp_wdata,
  output logic [7:0] accumulator,
  output logic [7:0] idx_rdata,
  output logic idx_second_sel,
  output logic [15:0] program_counter_reg,
  output logic [7:0] condition_flags_register,
  output logic [1:0] priority_level,
  output logic irq_disabled,
  output logic [7:0] alu_result,
  output logic branch_taken,
  output logic [15:0] stack_pointer_reg,
  output logic [15:0] stack_addr
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] acc;
  logic [7:0] idx_first;
  logic [7:0] idx_second;
  logic [7:0] program_counter_low;
  logic [7:0] program_counter_high;
  logic [7:0] cc;
  logic prefix_pend;
  logic [7:0] res_q;
  cpr_flag_if fl ();
  // ----------------------------------------------------------------
  // flag calculation and stack pointer
  // ----------------------------------------------------------------
  assign fl.kind = flag_upd ? flag_kind : cpr_pkg::FK_NONE;
  assign fl.opa = alu_a;
  assign fl.opb = alu_b;
  assign fl.cin = alu_cin;
  cpr_flag_calc u_calc (
    .fl(fl)
  );
  // RL19 sequencer issues two or five pushes, low PC byte first
  cpr_stack_ptr u_sp (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .push(sp_push),
    .pop(sp_pop),
    .reset_op(sp_reset_op),
    .load(sp_load),
    .load_val(sp_wdata),
    .sp(stack_pointer_reg),
    .addr(stack_addr)
  );
  // ----------------------------------------------------------------
  // index selection
  // ----------------------------------------------------------------
  // RL3 prefix holds until the next instruction completes
  wire logic use_second;
  wire logic next_prefix;
  assign use_second = prefix_pend;
  assign next_prefix = prefix_op ? 1'b1 : (instr_done ? 1'b0 : prefix_pend);
  wire logic wr_first;
  wire logic wr_second;
  // RL4 only an explicit index write reaches the second register
  assign wr_first = idx_we && !use_second;
  assign wr_second = idx_we && use_second;
  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  // RL5 byte halves load separately, increment carries across
  wire logic [15:0] pc_plus;
  wire logic [7:0] next_pc_low;
  wire logic [7:0] next_pc_high;
  assign pc_plus = {program_counter_high, program_counter_low} + 16'h0001;
  assign next_pc_low = pc_low_we ? pc_byte
                     : (pc_inc ? pc_plus[7:0] : program_counter_low);
  assign next_pc_high = pc_high_we ? pc_byte
                      : (pc_inc ? pc_plus[15:8] : program_counter_high);
  // ----------------------------------------------------------------
  // condition flags next value
  // ----------------------------------------------------------------
  wire logic [7:0] cc_arith;
  wire logic next_c;
  wire logic [1:0] op_pri;
  wire logic op_pri_hit;
  wire logic [1:0] next_pri;
  wire logic [7:0] next_cc;
  // RL13 forced carry wins over computed carry
  assign next_c = set_carry_op ? 1'b1
                : reset_carry_op ? 1'b0
                : fl.upd_c ? fl.carry : cc[cpr_pkg::CC_C];
  assign cc_arith = {cc[7:5],
                     fl.upd_h ? fl.half : cc[cpr_pkg::CC_H],
                     cc[cpr_pkg::CC_I0],
                     fl.upd_nz ? fl.neg : cc[cpr_pkg::CC_N],
                     fl.upd_nz ? fl.zero : cc[cpr_pkg::CC_Z],
                     next_c};
  // RL17 enable, halt and wait drop to main level; disable masks all
  assign op_pri_hit = interrupt_enable_op || interrupt_disable_op
                    || halt_op || wait_interrupt_op;
  assign op_pri = interrupt_disable_op ? cpr_pkg::PRI_LEVEL3
                                       : cpr_pkg::PRI_LEVEL0;
  // RL16 entry takes the serviced source's priority bits
  assign next_pri = irq_entry ? irq_pri_bits
                  : op_pri_hit ? op_pri
                  : {cc[cpr_pkg::CC_I1], cc[cpr_pkg::CC_I0]};
  // RL8 pop (also used by return) restores the whole register
  // RL20 top two bits forced to one
  assign next_cc = cc_pop ? (cc_wdata | cpr_pkg::CC_FIXED_ONES)
                 : {cc_arith[7:6], next_pri[1], cc_arith[4],
                    next_pri[0], cc_arith[2:0]};
  // ----------------------------------------------------------------
  // branch evaluation
  // ----------------------------------------------------------------
  // RL14 each flag tested set or clear
  wire logic [7:0] cond_vec;
  assign cond_vec = {!cc[cpr_pkg::CC_C], cc[cpr_pkg::CC_C],
                     !cc[cpr_pkg::CC_Z], cc[cpr_pkg::CC_Z],
                     !cc[cpr_pkg::CC_N], cc[cpr_pkg::CC_N],
                     !cc[cpr_pkg::CC_H], cc[cpr_pkg::CC_H]};
  assign branch_taken = |(cond_vec & branch_cond);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc <= 8'h00;
      idx_first <= 8'h00;
      idx_second <= 8'h00;
      prefix_pend <= 1'b0;
    end
    else if (clk_en)
    begin
      // RL1 accumulator load
      if (acc_we)
        acc <= acc_wdata;
      // RL2 index loads
      if (wr_first)
        idx_first <= idx_wdata;
      if (wr_second)
        idx_second <= idx_wdata;
      prefix_pend <= next_prefix;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      program_counter_low <= 8'h00;
      program_counter_high <= 8'h00;
      res_q <= 8'h00;
    end
    else if (clk_en)
    begin
      program_counter_low <= next_pc_low;
      program_counter_high <= next_pc_high;
      if (flag_upd)
        res_q <= fl.res;
    end
  end
  // RL7 reset pattern 111x1xxx
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      cc <= cpr_pkg::CC_RESET;
    else if (clk_en)
      cc <= next_cc;
  end
  // ----------------------------------------------------------------
  // outputs; no memory address decode exists for any of these
  // ----------------------------------------------------------------
  // RL6 dedicated ports only
  assign accumulator = acc;
  assign idx_rdata = use_second ? idx_second : idx_first;
  assign idx_second_sel = use_second;
  assign program_counter_reg = {program_counter_high, program_counter_low};
  assign condition_flags_register = cc;
  // RL15 level decode from bits 5 and 3
  assign priority_level = {cc[cpr_pkg::CC_I1], cc[cpr_pkg::CC_I0]};
  assign irq_disabled = (priority_level == cpr_pkg::PRI_LEVEL3);
  assign alu_result = res_q;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  fixed_ones_a: assert property (cc[7:6] == 2'h3) // RL20
    else $error("flags bits 7:6 not one");
  half_carry_a: assert property (clk_en && flag_upd && !cc_pop // RL9
    && flag_kind == cpr_pkg::FK_ADD
    |=> cc[cpr_pkg::CC_H] == ($past(alu_a[3:0]) + $past(alu_b[3:0])
        + $past(alu_cin) > 5'h0f))
    else $error("half carry wrong after add");
  neg_zero_a: assert property (clk_en && flag_upd && !cc_pop // RL10
    && flag_kind == cpr_pkg::FK_LOGIC
    |=> cc[cpr_pkg::CC_N] == $past(alu_b[7])
        && cc[cpr_pkg::CC_Z] == ($past(alu_b) == 8'h00))
    else $error("negative or zero flag wrong");
  add_zero_a: assert property (clk_en && flag_upd && !cc_pop // RL11
    && flag_kind == cpr_pkg::FK_ADD
    |=> cc[cpr_pkg::CC_Z]
        == ($past(alu_a) + $past(alu_b) + $past(alu_cin) == 8'h00))
    else $error("zero flag wrong after add");
  sub_borrow_a: assert property (clk_en && flag_upd && !cc_pop // RL12
    && !set_carry_op && !reset_carry_op
    && flag_kind == cpr_pkg::FK_SUB && alu_cin == 1'b0
    |=> cc[cpr_pkg::CC_C] == ($past(alu_a) < $past(alu_b)))
    else $error("borrow flag wrong");
  scf_a: assert property (clk_en && set_carry_op && !cc_pop // RL13
    |=> cc[cpr_pkg::CC_C])
    else $error("set carry op ignored");
  rcf_a: assert property (clk_en && reset_carry_op && !set_carry_op // RL13
    && !cc_pop |=> !cc[cpr_pkg::CC_C])
    else $error("reset carry op ignored");
  entry_pri_a: assert property (clk_en && irq_entry && !cc_pop // RL16
    |=> priority_level == $past(irq_pri_bits))
    else $error("entry did not load priority bits");
  sim_rim_a: assert property (clk_en && !irq_entry && !cc_pop // RL17
    && interrupt_disable_op ##1 clk_en && !irq_entry && !cc_pop
    && interrupt_enable_op && !interrupt_disable_op
    |-> irq_disabled ##1 priority_level == cpr_pkg::PRI_LEVEL0)
    else $error("priority ops misbehave");
  y_hold_a: assert property (!wr_second |=> $stable(idx_second)) // RL4
    else $error("second index changed without a write");
  prefix_sel_a: assert property (clk_en && prefix_op // RL3
    ##1 clk_en && idx_we |=> idx_second == $past(idx_wdata))
    else $error("prefix did not redirect index write");
  acc_load_a: assert property (clk_en && acc_we // RL1
    |=> accumulator == $past(acc_wdata))
    else $error("accumulator load lost");
  first_idx_a: assert property (clk_en && idx_we && !idx_second_sel // RL2
    && !prefix_op |=> idx_rdata == $past(idx_wdata))
    else $error("first index load lost");
  pc_inc_a: assert property (clk_en && pc_inc // RL5
    && !pc_low_we && !pc_high_we
    |=> program_counter_reg == $past(program_counter_reg) + 16'h0001)
    else $error("program counter did not increment");
  pc_low_a: assert property (clk_en && pc_low_we && !pc_high_we // RL5
    && !pc_inc |=> program_counter_reg
        == {$past(program_counter_reg[15:8]), $past(pc_byte)})
    else $error("program counter low byte load wrong");
  cc_pop_a: assert property (clk_en && cc_pop // RL8
    |=> cc == ($past(cc_wdata) | 8'hc0))
    else $error("flags pop mismatch");
  branch_a: assert property (branch_cond == cpr_pkg::BR_ZERO // RL14
    |-> branch_taken == cc[cpr_pkg::CC_Z])
    else $error("zero branch wrong");
  entry_c: cover property (clk_en && sp_push ##1 clk_en && irq_entry);
  pop_c: cover property (clk_en && cc_pop);
  add_c: cover property (clk_en && flag_upd && flag_kind == cpr_pkg::FK_ADD
    && fl.half);
  prefix_c: cover property (clk_en && prefix_op ##1 clk_en && idx_we);
  wrap_c: cover property (clk_en && sp_push
    && stack_pointer_reg == 16'h0100);
endmodule // cpr_regs
`default_nettype wire

// ==== bench/cpr_seq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// interrupt entry sequencer model
// ----------------------------------------------------------------
module cpr_seq_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [1:0] pri_in,
  output logic sp_push,
  output logic irq_entry,
  output logic [1:0] irq_pri_bits
);
  logic [2:0] cnt;
  assign sp_push = cnt != 3'h0 && cnt != 3'h6;
  assign irq_entry = cnt == 3'h6;
  // bits are garbage outside the entry cycle, the core must not sample them
  assign irq_pri_bits = irq_entry ? pri_in : ~pri_in;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt <= 3'h0;
    else if (start || cnt != 3'h0)
      cnt <= (cnt == 3'h6) ? 3'h0 : cnt + 3'h1;
  end
endmodule // cpr_seq_model
`default_nettype wire

// ==== bench/test_cpr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// register set bench
// ----------------------------------------------------------------
module test_cpr_regs;
  typedef struct packed {
    cpr_pkg::cpr_fkind_t k;
    logic [7:0] a;
    logic [7:0] b;
    logic ci;
    logic ck;
    logic [7:0] r;
    logic [3:0] f;
  } cpr_row_t;
  logic mclk, sys_rst, clk_en, instr_done, prefix_op, acc_we, idx_we;
  logic pc_low_we, pc_high_we, pc_inc, flag_upd, alu_cin, set_carry_op;
  logic reset_carry_op, cc_pop, irq_entry, interrupt_enable_op, halt_op;
  logic interrupt_disable_op, wait_interrupt_op, sp_push, sp_pop, sp_load;
  logic sp_reset_op, tb_push, m_push, irq_go, idx_second_sel, irq_disabled;
  logic branch_taken;
  logic [7:0] acc_wdata, idx_wdata, pc_byte, alu_a, alu_b, cc_wdata;
  logic [7:0] sp_wdata, accumulator, idx_rdata, condition_flags_register;
  logic [7:0] alu_result;
  logic [1:0] irq_pri_bits, irq_pri, priority_level;
  logic [15:0] program_counter_reg, stack_pointer_reg, stack_addr;
  cpr_pkg::cpr_fkind_t flag_kind;
  cpr_pkg::cpr_branch_t branch_cond;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  cpr_row_t rows [10] = '{
    '{cpr_pkg::FK_ADD, 8'h0f, 8'h01, 1'h0, 1'h1, 8'h10, 4'h8},
    '{cpr_pkg::FK_ADD, 8'hff, 8'h01, 1'h0, 1'h1, 8'h00, 4'hb},
    '{cpr_pkg::FK_ADD, 8'h7f, 8'h00, 1'h1, 1'h1, 8'h80, 4'hc},
    '{cpr_pkg::FK_SUB, 8'h00, 8'h01, 1'h0, 1'h1, 8'hff, 4'hd},
    '{cpr_pkg::FK_LOGIC, 8'hff, 8'h00, 1'h0, 1'h1, 8'h00, 4'hb},
    '{cpr_pkg::FK_SUB, 8'h05, 8'h04, 1'h1, 1'h1, 8'h00, 4'ha},
    '{cpr_pkg::FK_SHIFT, 8'h00, 8'h81, 1'h1, 1'h1, 8'h81, 4'hd},
    '{cpr_pkg::FK_BTJ, 8'h00, 8'h00, 1'h0, 1'h0, 8'h00, 4'hc},
    '{cpr_pkg::FK_ADD, 8'h88, 8'h88, 1'h0, 1'h1, 8'h10, 4'h9},
    '{cpr_pkg::FK_ADD, 8'h01, 8'h01, 1'h0, 1'h1, 8'h02, 4'h0}};
  logic [5:0] pri_tab [6] = '{6'h23, 6'h12, 6'h23, 6'h0a, 6'h23, 6'h06};
  assign sp_push = tb_push | m_push;
  cpr_seq_model u_cpr_seq_model (.mclk, .sys_rst, .start(irq_go),
    .pri_in(irq_pri), .sp_push(m_push), .irq_entry, .irq_pri_bits);
  cpr_regs u_cpr_regs (.mclk, .sys_rst, .clk_en, .instr_done, .prefix_op,
    .acc_we, .acc_wdata, .idx_we, .idx_wdata, .pc_low_we, .pc_high_we,
    .pc_byte, .pc_inc, .flag_upd, .flag_kind, .alu_a, .alu_b, .alu_cin,
    .set_carry_op, .reset_carry_op, .cc_pop, .cc_wdata, .irq_entry,
    .irq_pri_bits, .interrupt_enable_op, .interrupt_disable_op, .halt_op,
    .wait_interrupt_op, .branch_cond, .sp_push, .sp_pop, .sp_reset_op,
    .sp_load, .sp_wdata, .accumulator, .idx_rdata, .idx_second_sel,
    .program_counter_reg, .condition_flags_register, .priority_level,
    .irq_disabled, .alu_result, .branch_taken, .stack_pointer_reg,
    .stack_addr);
  function automatic logic [7:0] ccv(input logic [1:0] p,
                                     input logic [3:0] f);
    return {2'h3, p[1], f[3], p[0], f[2:0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic idle();
    {instr_done, prefix_op, acc_we, idx_we, pc_low_we, pc_high_we} = 6'h00;
    {pc_inc, flag_upd, set_carry_op, reset_carry_op, cc_pop} = 5'h00;
    {interrupt_enable_op, interrupt_disable_op, halt_op} = 3'h0;
    {wait_interrupt_op, tb_push, sp_pop, sp_reset_op, sp_load} = 5'h00;
    irq_go = 1'b0;
    clk_en = 1'b1;
    branch_cond = cpr_pkg::cpr_branch_t'(8'h00);
  endtask
  task automatic go();
    @(posedge mclk);
    @(negedge mclk);
    idle();
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    idle();
    {acc_wdata, idx_wdata, pc_byte, alu_a, alu_b, cc_wdata} = 48'h0;
    {sp_wdata, alu_cin, irq_pri} = 11'h0;
    flag_kind = cpr_pkg::FK_NONE;
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    chk("cc reset", 16'h00e8, condition_flags_register);
    chk("sp reset", 16'h01ff, stack_pointer_reg);
    chk("level reset", 16'h0003, priority_level);
    chk("off at reset", 16'h0001, irq_disabled);
    foreach (rows[i])
    begin
      flag_upd = 1'b1;
      flag_kind = rows[i].k;
      alu_a = rows[i].a;
      alu_b = rows[i].b;
      alu_cin = rows[i].ci;
      go();
      chk("flags", ccv(2'h3, rows[i].f), condition_flags_register);
      if (rows[i].ck)
        chk("result", rows[i].r, alu_result);
      for (int j = 0; j < 8; j++)
      begin
        branch_cond = cpr_pkg::cpr_branch_t'(8'h01 << j);
        #1;
        chk("branch", rows[i].f[3 - j / 2] ^ j[0], branch_taken);
      end
      branch_cond = cpr_pkg::cpr_branch_t'(8'h00);
    end
    {set_carry_op, reset_carry_op, flag_upd} = 3'h5;
    go();
    chk("set over add", 16'h00e9, condition_flags_register);
    {set_carry_op, reset_carry_op} = 2'h1;
    go();
    chk("reset carry", 16'h00e8, condition_flags_register);
    {set_carry_op, reset_carry_op} = 2'h3;
    go();
    chk("set wins", 16'h00e9, condition_flags_register);
    foreach (pri_tab[i])
    begin
      {interrupt_disable_op, interrupt_enable_op, halt_op} = pri_tab[i][5:3];
      wait_interrupt_op = pri_tab[i][2];
      go();
      chk("level", pri_tab[i][1:0], priority_level);
      chk("disabled", pri_tab[i][1:0] == 2'h3, irq_disabled);
    end
    {cc_pop, cc_wdata} = 9'h100;
    go();
    chk("pop low", 16'h00c0, condition_flags_register);
    {cc_pop, cc_wdata} = 9'h13f;
    go();
    chk("pop high", 16'h00ff, condition_flags_register);
    {acc_we, acc_wdata} = 9'h15a;
    go();
    {clk_en, acc_we, acc_wdata} = 10'h199;
    go();
    chk("acc", 16'h005a, accumulator);
    {idx_we, idx_wdata} = 9'h111;
    go();
    prefix_op = 1'b1;
    go();
    chk("prefix", 16'h0001, idx_second_sel);
    {idx_we, idx_wdata, instr_done} = 10'h245;
    go();
    chk("first idx", 16'h0011, idx_rdata);
    {irq_go, irq_pri} = 3'h5;
    repeat (7) go();
    chk("irq level", 16'h0001, priority_level);
    chk("ctx sp", 16'h01fa, stack_pointer_reg);
    prefix_op = 1'b1;
    go();
    chk("second idx", 16'h0022, idx_rdata);
    {sp_reset_op, instr_done} = 2'h3;
    go();
    sp_pop = 1'b1;
    #1;
    chk("pop addr", 16'h0100, stack_addr);
    go();
    chk("pop wrap", 16'h0100, stack_pointer_reg);
    tb_push = 1'b1;
    go();
    chk("push wrap", 16'h01ff, stack_pointer_reg);
    {sp_load, sp_wdata} = 9'h180;
    go();
    chk("sp load", 16'h0180, stack_pointer_reg);
    {pc_low_we, pc_byte} = 9'h1ff;
    go();
    {pc_high_we, pc_byte} = 9'h112;
    go();
    pc_inc = 1'b1;
    go();
    chk("pc carry", 16'h1300, program_counter_reg);
    sys_rst = 1'b1;
    go();
    sys_rst = 1'b0;
    chk("cc rerst", 16'h00e8, condition_flags_register);
    chk("acc rerst", 16'h0000, accumulator);
    summarize();
  end
endmodule // test_cpr_regs
`default_nettype wire
